// file: hdl/clkgen_regs_consts.vh
// Register offsets, field positions, reset values and timing figures
`ifndef CLKGEN_REGS_CONSTS_VH
`define CLKGEN_REGS_CONSTS_VH
// Register indices; byte address is four times the index
`define IDX_LOCK_DETECT 8'h21
`define IDX_FRAC_UPPER 8'h23
`define IDX_FRAC_LOWER 8'h24
`define IDX_INTDIV_CFG 8'h25
// Extra control and status words
`define IDX_PRESCALER_CFG 8'h1E
`define IDX_STATUS 8'h30
// Reset values
`define RST_LOCK_DETECT 16'h0007
`define RST_FRAC_UPPER 16'h8000
`define RST_FRAC_LOWER 16'h0000
`define RST_INTDIV_CFG 16'h8003
`define RST_PRESCALER_CFG 16'h0000
// Field positions
`define PFD_DLY_HI 6
`define PFD_DLY_LO 5
`define LD_WIN_HI 4
`define LD_WIN_LO 2
`define LD_WAIT_HI 1
`define LD_WAIT_LO 0
`define FRAC_LOW_HI 8
`define SRC_HI 15
`define SRC_LO 14
`define RATIO_HI 13
`define RATIO_LO 0
// Writable masks (reserved bits read as zero)
`define MASK_LOCK_DETECT 16'h007F
`define MASK_FRAC_LOWER 16'h01FF
`define MASK_PRESCALER_CFG 16'h000F
// Source codes
`define SRC_PSA 2'h0
`define SRC_PSB 2'h1
`define SRC_FRAC 2'h2
`define SRC_REF 2'h3
// Lock window in tenths of ns, per code
`define WIN_T1 7'h0E
`define WIN_T2 7'h1A
`define WIN_T3 7'h27
`define WIN_T4 7'h34
`define WIN_T5 7'h40
`define WIN_T6 7'h4C
`define WIN_T7 7'h59
`endif

// file: hdl/clk_divider.v
// Programmable clock divider for the integer-divider stage
`timescale 1ns/10ps
module clk_divider #(
  parameter WIDTH = 14
) (
  input wire core_clk,
  input wire srst,
  input wire clk_en_in,
  input wire [WIDTH-1:0] ratio,
  output reg tick_ff,
  output reg powered_ff
);
  reg [WIDTH-1:0] cnt_ff;
  wire [WIDTH-1:0] last = ratio - {{(WIDTH-1){1'b0}}, 1'b1};

  // Count input enables; ratio zero holds the divider powered down
  always @(posedge core_clk) begin
    if (srst) begin
      cnt_ff <= {WIDTH{1'b0}};
      tick_ff <= 1'b0;
      powered_ff <= 1'b0;
    end else begin
      powered_ff <= (ratio != {WIDTH{1'b0}});
      tick_ff <= 1'b0;
      if (ratio == {WIDTH{1'b0}}) begin
        cnt_ff <= {WIDTH{1'b0}};
      end else if (clk_en_in) begin
        if (cnt_ff >= last) begin
          cnt_ff <= {WIDTH{1'b0}};
          tick_ff <= 1'b1;
        end else begin
          cnt_ff <= cnt_ff + {{(WIDTH-1){1'b0}}, 1'b1};
        end
      end
    end
  end
endmodule // clk_divider

// file: hdl/pll_ch1_regs.v
// Lock-detect and channel 1 divider register bank over APB
// What this block does
// - PFD reset delay bits 6-5: 2/6/10/14
// - Lock window bits 4-2, reset 1, 0 disables
// - Window codes 1-7 give 1.4 to 8.9 ns
// - Lock wait bits 1-0: 1/16/64/128 cycles
// - Fraction upper 16 bits, fraction bits 24-9
// - Fraction lower 9 bits, 15-9 reserved
// - Divider source bits 15-14, reset fraction
// - Ratio bits 13-0, zero powers down divider
// - Prescalers divide by 4, 5 or 6
`timescale 1ns/10ps
`include "clkgen_regs_consts.vh"
module pll_ch1_regs (
  input wire core_clk,
  input wire srst,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire [3:0] pstrb,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  input wire ref_tick,
  input wire vco_tick,
  input wire frac_tick,
  input wire phase_err_valid,
  input wire [6:0] phase_err,
  output reg [3:0] pfd_reset_delay_ff,
  output reg [6:0] lock_window_ff,
  output reg lock_window_en_ff,
  output reg [7:0] lock_wait_cycles_ff,
  output reg [24:0] ch1_fraction_ff,
  output reg locked_ff,
  output reg ch1_out_tick_ff,
  output reg ch1_intdiv_on_ff
);
  reg [15:0] lock_cfg_ff;
  reg [15:0] ch1_fraction_high;
  reg [8:0] ch1_fraction_low;
  reg [1:0] ch1_intdiv_source;
  reg [13:0] ch1_intdiv_ratio;
  reg [3:0] presc_cfg_ff;
  reg [2:0] psa_cnt_ff;
  reg [2:0] psb_cnt_ff;
  reg psa_tick_ff;
  reg psb_tick_ff;
  reg [7:0] lock_cnt_ff;
  reg [31:0] nxt_prdata;
  reg nxt_err;
  reg [15:0] wr16;
  reg [15:0] cur16;
  reg div_in;
  wire div_tick;
  wire div_on;

  wire setup = psel & ~penable;
  wire [9:0] idx = paddr[11:2];
  wire access = psel & penable & pready;
  wire wr_acc = access & pwrite & ~pslverr;

  // Look up the last count (divide-by minus one) for a prescaler code
  function [2:0] presc_last;
    input [1:0] code;
    begin
      case (code)
        2'h0: presc_last = 3'h3;
        2'h1: presc_last = 3'h4;
        2'h2: presc_last = 3'h5;
        default: presc_last = 3'h5;
      endcase
    end
  endfunction

  // Address decode and read mux in the setup cycle
  always @* begin
    nxt_prdata = 32'h00000000;
    nxt_err = 1'b0;
    cur16 = 16'h0000;
    case (idx)
      {2'h0, `IDX_LOCK_DETECT}: cur16 = lock_cfg_ff;
      {2'h0, `IDX_FRAC_UPPER}: cur16 = ch1_fraction_high;
      {2'h0, `IDX_FRAC_LOWER}: cur16 = {7'h00, ch1_fraction_low};
      {2'h0, `IDX_INTDIV_CFG}: cur16 = {ch1_intdiv_source,
                                        ch1_intdiv_ratio};
      {2'h0, `IDX_PRESCALER_CFG}: cur16 = {12'h000, presc_cfg_ff};
      {2'h0, `IDX_STATUS}: cur16 = {14'h0000, div_on, locked_ff};
      default: nxt_err = 1'b1;
    endcase
    nxt_prdata = {16'h0000, cur16};
    // Byte strobes merge into the current value
    wr16[7:0] = pstrb[0] ? pwdata[7:0] : cur16[7:0];
    wr16[15:8] = pstrb[1] ? pwdata[15:8] : cur16[15:8];
  end

  // APB slave: no wait states, answer in the first access cycle
  always @(posedge core_clk) begin
    if (srst) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else if (setup) begin
      pready <= 1'b1;
      pslverr <= nxt_err;
      prdata <= pwrite ? 32'h00000000 : nxt_prdata;
    end else begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // Register writes; reserved bits are masked so they read as zero
  always @(posedge core_clk) begin
    if (srst) begin
      lock_cfg_ff <= `RST_LOCK_DETECT;
      ch1_fraction_high <= `RST_FRAC_UPPER;
      ch1_fraction_low <= 9'h000;
      ch1_intdiv_source <= `SRC_FRAC;
      ch1_intdiv_ratio <= 14'h0003;
      presc_cfg_ff <= 4'h0;
    end else if (wr_acc) begin
      case (idx)
        {2'h0, `IDX_LOCK_DETECT}:
          lock_cfg_ff <= wr16 & `MASK_LOCK_DETECT;
        {2'h0, `IDX_FRAC_UPPER}: ch1_fraction_high <= wr16;
        {2'h0, `IDX_FRAC_LOWER}:
          ch1_fraction_low <= wr16[`FRAC_LOW_HI:0];
        {2'h0, `IDX_INTDIV_CFG}: begin
          ch1_intdiv_source <= wr16[`SRC_HI:`SRC_LO];
          ch1_intdiv_ratio <= wr16[`RATIO_HI:`RATIO_LO];
        end
        {2'h0, `IDX_PRESCALER_CFG}:
          presc_cfg_ff <= wr16[3:0]; // All four bits are writable
        default: ;
      endcase
    end
  end

  // Decode lock-detect settings into usable values
  always @(posedge core_clk) begin
    if (srst) begin
      pfd_reset_delay_ff <= 4'h2;
      lock_window_ff <= `WIN_T1;
      lock_window_en_ff <= 1'b1;
      lock_wait_cycles_ff <= 8'h80;
      ch1_fraction_ff <= 25'h1000000;
    end else begin
      pfd_reset_delay_ff <= {lock_cfg_ff[`PFD_DLY_HI:`PFD_DLY_LO], 2'h2};
      case (lock_cfg_ff[`LD_WIN_HI:`LD_WIN_LO])
        3'h1: lock_window_ff <= `WIN_T1;
        3'h2: lock_window_ff <= `WIN_T2;
        3'h3: lock_window_ff <= `WIN_T3;
        3'h4: lock_window_ff <= `WIN_T4;
        3'h5: lock_window_ff <= `WIN_T5;
        3'h6: lock_window_ff <= `WIN_T6;
        3'h7: lock_window_ff <= `WIN_T7;
        default: lock_window_ff <= 7'h00;
      endcase
      // Code zero turns the window comparison off
      lock_window_en_ff <=
        (lock_cfg_ff[`LD_WIN_HI:`LD_WIN_LO] != 3'h0);
      case (lock_cfg_ff[`LD_WAIT_HI:`LD_WAIT_LO])
        2'h0: lock_wait_cycles_ff <= 8'h01;
        2'h1: lock_wait_cycles_ff <= 8'h10;
        2'h2: lock_wait_cycles_ff <= 8'h40;
        default: lock_wait_cycles_ff <= 8'h80;
      endcase
      ch1_fraction_ff <= {ch1_fraction_high, ch1_fraction_low};
    end
  end

  // Lock timer counts clean PFD cycles; a miss restarts it
  always @(posedge core_clk) begin
    if (srst) begin
      lock_cnt_ff <= 8'h00;
      locked_ff <= 1'b0;
    end else if (phase_err_valid) begin
      if (lock_window_en_ff && phase_err > lock_window_ff) begin
        lock_cnt_ff <= 8'h00;
        locked_ff <= 1'b0;
      end else if (lock_cnt_ff + 8'h01 >= lock_wait_cycles_ff) begin
        locked_ff <= 1'b1;
        lock_cnt_ff <= lock_wait_cycles_ff;
      end else begin
        lock_cnt_ff <= lock_cnt_ff + 8'h01;
      end
    end
  end

  // Prescalers A and B on the VCO tick
  always @(posedge core_clk) begin
    if (srst) begin
      psa_cnt_ff <= 3'h0;
      psb_cnt_ff <= 3'h0;
      psa_tick_ff <= 1'b0;
      psb_tick_ff <= 1'b0;
    end else begin
      psa_tick_ff <= 1'b0;
      psb_tick_ff <= 1'b0;
      if (vco_tick) begin
        if (psa_cnt_ff >= presc_last(presc_cfg_ff[1:0])) begin
          psa_cnt_ff <= 3'h0;
          psa_tick_ff <= 1'b1;
        end else begin
          psa_cnt_ff <= psa_cnt_ff + 3'h1;
        end
        if (psb_cnt_ff >= presc_last(presc_cfg_ff[3:2])) begin
          psb_cnt_ff <= 3'h0;
          psb_tick_ff <= 1'b1;
        end else begin
          psb_cnt_ff <= psb_cnt_ff + 3'h1;
        end
      end
    end
  end

  // Integer divider input mux
  always @* begin
    case (ch1_intdiv_source)
      `SRC_PSA: div_in = psa_tick_ff;
      `SRC_PSB: div_in = psb_tick_ff;
      `SRC_FRAC: div_in = frac_tick;
      default: div_in = ref_tick;
    endcase
  end

  // Divider powers down when the ratio is zero
  clk_divider #(.WIDTH(14)) u_intdiv (
    .core_clk(core_clk),
    .srst(srst),
    .clk_en_in(div_in),
    .ratio(ch1_intdiv_ratio),
    .tick_ff(div_tick),
    .powered_ff(div_on)
  );

  // Register divider outputs
  always @(posedge core_clk) begin
    if (srst) begin
      ch1_out_tick_ff <= 1'b0;
      ch1_intdiv_on_ff <= 1'b0;
    end else begin
      ch1_out_tick_ff <= div_tick;
      ch1_intdiv_on_ff <= div_on;
    end
  end
endmodule // pll_ch1_regs

// file: test/pll_ch1_regs_properties.sv
// Checker for bus timing and field decode of the lock and channel 1 bank
`timescale 1ns/10ps
`include "clkgen_regs_consts.vh"
module pll_ch1_regs_checker (
  input logic core_clk,
  input logic srst,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [11:0] paddr,
  input logic [31:0] pwdata,
  input logic pready,
  input logic pslverr,
  input logic [3:0] pfd_reset_delay_ff,
  input logic [6:0] lock_window_ff,
  input logic lock_window_en_ff,
  input logic [7:0] lock_wait_cycles_ff,
  input logic [24:0] ch1_fraction_ff,
  input logic ch1_intdiv_on_ff
);
  logic [15:0] wd_ff;
  wire [9:0] idx = paddr[11:2];
  wire mapped = idx == `IDX_LOCK_DETECT || idx == `IDX_FRAC_UPPER ||
    idx == `IDX_FRAC_LOWER || idx == `IDX_INTDIV_CFG ||
    idx == `IDX_PRESCALER_CFG || idx == `IDX_STATUS;
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  // Hold the last written word, since decoded outputs lag it by an edge
  always @(posedge core_clk) begin
    if (psel && penable && pready && pwrite) wd_ff <= pwdata[15:0];
  end
  sequence commit(i);
    psel && penable && pready && pwrite && idx == i;
  endsequence
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_pulse: assert property (pready |=> !pready)
    else $error("ready held too long");
  a_err_map: assert property (pready |-> pslverr == !mapped)
    else $error("wrong error response");
  a_delay_decode: assert property (commit(`IDX_LOCK_DETECT) |->
    ##[1:2] pfd_reset_delay_ff == 4'h2 + {wd_ff[6:5], 2'h0})
    else $error("bad reset delay");
  a_window_off: assert property (commit(`IDX_LOCK_DETECT)
    ##0 pwdata[4:2] == 3'h0 |-> ##[1:2] !lock_window_en_ff)
    else $error("window not disabled");
  a_wait_decode: assert property (commit(`IDX_LOCK_DETECT) |->
    ##[1:2] lock_wait_cycles_ff == (wd_ff[1:0] == 2'h0 ? 8'h01 :
    wd_ff[1:0] == 2'h1 ? 8'h10 : wd_ff[1:0] == 2'h2 ? 8'h40 : 8'h80))
    else $error("bad wait count");
  a_fraction_high: assert property (commit(`IDX_FRAC_UPPER) |->
    ##[1:2] ch1_fraction_ff[24:9] == wd_ff)
    else $error("bad upper fraction");
  a_fraction_low: assert property (commit(`IDX_FRAC_LOWER) |->
    ##[1:2] ch1_fraction_ff[8:0] == wd_ff[8:0])
    else $error("bad lower fraction");
  a_divider_off: assert property (commit(`IDX_INTDIV_CFG)
    ##0 pwdata[13:0] == 14'h0 |-> ##[1:3] !ch1_intdiv_on_ff)
    else $error("divider still on");
endmodule // pll_ch1_regs_checker
bind pll_ch1_regs pll_ch1_regs_checker checker_i (.core_clk(core_clk),
  .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr),
  .pfd_reset_delay_ff(pfd_reset_delay_ff), .lock_window_ff(lock_window_ff),
  .lock_window_en_ff(lock_window_en_ff),
  .lock_wait_cycles_ff(lock_wait_cycles_ff),
  .ch1_fraction_ff(ch1_fraction_ff), .ch1_intdiv_on_ff(ch1_intdiv_on_ff));

// file: test/pll_ch1_regs_test.sv
// Self-checking bench for the lock and channel 1 register bank
`timescale 1ns/10ps
`include "clkgen_regs_consts.vh"
module pll_ch1_regs_test;
  localparam [9:0] i_lk = `IDX_LOCK_DETECT, i_hi = `IDX_FRAC_UPPER;
  localparam [9:0] i_lo = `IDX_FRAC_LOWER, i_dv = `IDX_INTDIV_CFG;
  logic core_clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, v, hi, lo, lfsr = 32'h134A;
  logic phase_err_valid = 0, pready, pslverr, locked_ff, err, en, on, tk;
  int n;
  logic [6:0] phase_err = 7'h00, win;
  logic [3:0] dly;
  logic [7:0] wt;
  logic [24:0] frac;
  logic [6:0] win_tab [8] = '{7'h00, 7'h0E, 7'h1A, 7'h27, 7'h34, 7'h40,
    7'h4C, 7'h59};
  logic [7:0] wait_tab [4] = '{8'h01, 8'h10, 8'h40, 8'h80};
  int n_fail = 0, n_compared = 0;
  always #5 core_clk = ~core_clk;
  // Source ticks run every cycle; the strobes always enable both lanes
  pll_ch1_regs uut (.core_clk(core_clk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .pstrb(4'hF), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ref_tick(1'b1), .vco_tick(1'b1), .frac_tick(1'b1),
    .phase_err_valid(phase_err_valid), .phase_err(phase_err),
    .pfd_reset_delay_ff(dly), .lock_window_ff(win),
    .lock_window_en_ff(en), .lock_wait_cycles_ff(wt),
    .ch1_fraction_ff(frac), .locked_ff(locked_ff),
    .ch1_out_tick_ff(tk), .ch1_intdiv_on_ff(on));
  function logic [31:0] rnd();
    lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
    return lfsr;
  endfunction
  task chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One transfer; two idle edges after it let the decoded outputs settle
  task apb(input logic wr, input logic [9:0] idx, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {idx, 2'h0};
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(posedge core_clk);
  endtask
  task rd_chk(input string n, input logic [9:0] i, input logic [31:0] e,
    input logic ee);
    apb(1'b0, i, 32'h0);
    chk(n, e, rd);
    chk("pslverr", ee, err);
  endtask
  task print_verdict();
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  // Watchdog sized well above the few hundred cycles the tests need
  initial begin
    repeat (4000) @(posedge core_clk);
    n_fail++;
    print_verdict();
  end
  initial begin
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    rd_chk("lock", i_lk, 32'h7, 1'b0);
    rd_chk("upper", i_hi, 32'h8000, 1'b0);
    rd_chk("lower", i_lo, 32'h0, 1'b0);
    rd_chk("intdiv", i_dv, 32'h8003, 1'b0);
    chk("delay", 2, dly);
    chk("fraction", 32'h1000000, frac);
    $display("test reset done");
    for (int c = 0; c < 8; c++) begin
      v = {c[1:0], c[2:0], c[1:0]};
      apb(1'b1, i_lk, v);
      rd_chk("lock", i_lk, v, 1'b0);
      chk("delay", 2 + 4 * (c % 4), dly);
      chk("window", win_tab[c], win);
      chk("window on", c != 0, en);
      chk("wait", wait_tab[c % 4], wt);
    end
    $display("test lock codes done");
    for (int i = 0; i < 5; i++) begin
      hi = i == 0 ? 32'hFFFF : rnd() & 32'hFFFF;
      lo = i == 0 ? 32'h1FF : rnd() & 32'h1FF;
      apb(1'b1, i_hi, hi);
      apb(1'b1, i_lo, lo);
      rd_chk("upper", i_hi, hi, 1'b0);
      rd_chk("lower", i_lo, lo, 1'b0);
      chk("fraction", {hi[15:0], lo[8:0]}, frac);
    end
    $display("test fraction done");
    for (int s = 0; s < 4; s++) begin
      v = rnd() % 32'h3FFF + 1;
      v = {s[1:0], v[13:0]};
      apb(1'b1, i_dv, v);
      rd_chk("intdiv", i_dv, v, 1'b0);
      chk("divider on", 1, on);
    end
    apb(1'b1, i_dv, 32'h8000);
    @(posedge core_clk);
    chk("divider on", 0, on);
    rd_chk("status", `IDX_STATUS, 32'h0, 1'b0);
    apb(1'b1, 10'h3FF, 32'hFFFF);
    rd_chk("unmapped", 10'h3FF, 32'h0, 1'b1);
    $display("test divider done");
    // Prescaler A at /4, B at /6; divide by one shows the prescaler rate
    apb(1'b1, `IDX_PRESCALER_CFG, 32'h8);
    rd_chk("prescaler", `IDX_PRESCALER_CFG, 32'h8, 1'b0);
    for (int p = 0; p < 2; p++) begin
      apb(1'b1, i_dv, p ? 32'h4001 : 32'h0001);
      repeat (8) @(posedge core_clk);
      n = 0;
      repeat (p ? 60 : 40) begin
        @(posedge core_clk);
        n += tk;
      end
      chk("ticks", 10, n);
    end
    $display("test prescaler done");
    // Window 1.4 ns, wait 16 samples: lock only after the full count
    apb(1'b1, i_lk, 32'h5);
    phase_err <= 7'h05;
    phase_err_valid <= 1'b1;
    repeat (10) @(posedge core_clk);
    chk("locked", 0, locked_ff);
    repeat (14) @(posedge core_clk);
    chk("locked", 1, locked_ff);
    phase_err <= 7'h20;
    repeat (3) @(posedge core_clk);
    chk("locked", 0, locked_ff);
    phase_err_valid <= 1'b0;
    $display("test lock detect done");
    print_verdict();
  end
endmodule // pll_ch1_regs_test
